// >>> rtl/sac_consts.svh
// Summary of operation
// - Host lowers select and lane together, write strobe one cycle later
// - First rising strobe edge ends the write
// - Host times data against the ending edge
// - Address valid by chip select falling edge
// - Write pulse covers setup plus release time
// - Host waits for device release before driving
// - Write strobe stays high during reads
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// pin, data and timer counter widths
`define SAC_ADDR_W 17
`define SAC_DATA_W 16
`define SAC_LANE_W 8
`define SAC_CNT_W 4

// system clock period in ns
`define SAC_CLK_NS 10
// address to data, least wait before sampling, ns
`define SAC_T_ACCESS_NS 10
// least write strobe pulse width, ns
`define SAC_T_WE_PULSE_NS 7
// data setup to write end, ns
`define SAC_DATA_SETUP_TIME_NS 5
// write strobe low to outputs released, ns
`define SAC_OUTPUT_RELEASE_TIME_NS 5
// output enable high to released, ns
`define SAC_T_OE_RELEASE_NS 5
// byte lane disable to released, ns
`define SAC_T_LANE_RELEASE_NS 6

// least times round up to whole cycles
`define SAC_CEIL_CYC(ns) (((ns) + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_MAX(a, b) (((a) > (b)) ? (a) : (b))
// read access cycles
`define SAC_RD_CYC `SAC_CEIL_CYC(`SAC_T_ACCESS_NS)
// write pulse covers both the pulse width and setup plus release
`define SAC_WR_CYC `SAC_CEIL_CYC(`SAC_MAX(`SAC_T_WE_PULSE_NS, \
  `SAC_DATA_SETUP_TIME_NS + `SAC_OUTPUT_RELEASE_TIME_NS))
// bus turnaround after a read before the host may drive
`define SAC_TURN_CYC `SAC_CEIL_CYC(`SAC_MAX(`SAC_T_OE_RELEASE_NS, `SAC_T_LANE_RELEASE_NS))

// reset level of the strobe pins (all inactive)
`define SAC_STROBE_IDLE 1'b1
`define SAC_LANES_IDLE 2'b11

`endif

// >>> rtl/sac_pkg.sv
package sac_pkg;

  // one-hot controller states
  typedef enum logic [5:0] {
    SAC_IDLE     = 6'b000001,
    SAC_RD_ACT   = 6'b000010,
    SAC_RD_TURN  = 6'b000100,
    SAC_WR_SETUP = 6'b001000,
    SAC_WR_PULSE = 6'b010000,
    SAC_WR_END   = 6'b100000
  } sac_state_e;

  // widen a two-bit lane select to a per-bit mask
  function automatic logic [15:0] sac_lane_mask(input logic [1:0] lanes);
    sac_lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}};
  endfunction : sac_lane_mask

  // an empty lane select means the whole word
  function automatic logic [1:0] sac_lanes_eff(input logic [1:0] be);
    sac_lanes_eff = (be == 2'h0) ? 2'h3 : be;
  endfunction : sac_lanes_eff

endpackage : sac_pkg

// >>> rtl/sac_tmr_if.sv
`timescale 1ns/1ps
// carries the phase timer between controller and counter
interface sac_tmr_if;
  logic load; // load the counter this cycle
  logic [3:0] value; // cycles minus one to run
  logic expired; // counter has reached zero
  modport ctl (output load, output value, input expired);
  modport tmr (input load, input value, output expired);
endinterface : sac_tmr_if

// >>> rtl/sac_phase_timer.sv
`timescale 1ns/1ps
`include "sac_consts.svh"

// counts down the length of one pin phase
module sac_phase_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  // timer carrier
  sac_tmr_if.tmr tif
);

  logic [`SAC_CNT_W-1:0] cnt_q; // remaining cycles

  // load on request, else count down to zero and stay
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 4'h0;
    end else if (clk_en) begin
      if (tif.load) begin
        cnt_q <= tif.value;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end

  // zero means the phase has run its length
  assign tif.expired = (cnt_q == 4'h0);

endmodule : sac_phase_timer

// >>> rtl/sac_host.sv
`timescale 1ns/1ps
`include "sac_consts.svh"

// host side controller for a 16-bit asynchronous static ram
module sac_host (
  // clock, reset, freeze
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  // user request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [`SAC_ADDR_W-1:0] req_addr,
  input wire logic [`SAC_DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_be,
  output logic req_ready,
  // user answer
  output logic rd_valid,
  output logic [`SAC_DATA_W-1:0] rd_data,
  output logic wr_done,
  // memory pins
  output logic [`SAC_ADDR_W-1:0] sram_addr,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_strobe_n,
  output logic lower_byte_lane_n,
  output logic upper_byte_lane_n,
  // two-way data pins
  input wire logic [`SAC_DATA_W-1:0] dq_i,
  output logic [`SAC_DATA_W-1:0] dq_o,
  output logic [`SAC_DATA_W-1:0] dq_oe
);

  sac_pkg::sac_state_e state_q; // current phase
  logic rdy_q; // ready for a new request
  logic rd_valid_q; // read data pulse
  logic wr_done_q; // write finished pulse
  logic [`SAC_DATA_W-1:0] rd_data_q; // captured read word
  logic [`SAC_ADDR_W-1:0] addr_q; // address pins
  logic cs_n_q; // chip select pin
  logic oe_n_q; // output enable pin
  logic we_n_q; // write strobe pin
  logic [1:0] lanes_n_q; // byte lane pins, bit 0 lower
  logic [`SAC_DATA_W-1:0] dq_o_q; // write data pins
  logic [`SAC_DATA_W-1:0] dq_oe_q; // data pin drive enables
  logic accept; // request taken this cycle
  logic [1:0] lanes; // effective lane select of the request
  logic tmr_exp; // phase timer has run out

  sac_tmr_if tif ();

  // phase timer
  sac_phase_timer u_timer (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .tif(tif)
  );

  // request taken only while idle and ready
  assign accept = req_valid && rdy_q && (state_q == sac_pkg::SAC_IDLE);
  // at least one lane is always selected
  assign lanes = sac_pkg::sac_lanes_eff(req_be);
  assign tmr_exp = tif.expired;

  // timer loads at the start of each timed phase
  always_comb begin
    tif.load = 1'b0;
    tif.value = 4'h0;
    unique case (state_q)
      // read access time before sampling
      sac_pkg::SAC_IDLE: begin
        if (accept && !req_write) begin
          tif.load = 1'b1;
          tif.value = 4'(`SAC_RD_CYC - 1);
        end
      end
      // release time before the host may drive again
      sac_pkg::SAC_RD_ACT: begin
        if (tmr_exp) begin
          tif.load = 1'b1;
          tif.value = 4'(`SAC_TURN_CYC - 1);
        end
      end
      // write strobe width
      sac_pkg::SAC_WR_SETUP: begin
        tif.load = 1'b1;
        tif.value = 4'(`SAC_WR_CYC - 1);
      end
      // phases that load no timer
      default: begin
        tif.load = 1'b0;
        tif.value = 4'h0;
      end
    endcase
  end

  // phase sequencing
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= sac_pkg::SAC_IDLE;
    end else if (clk_en) begin
      unique case (state_q)
        // wait for a request
        sac_pkg::SAC_IDLE: begin
          if (accept) begin
            state_q <= req_write ? sac_pkg::SAC_WR_SETUP : sac_pkg::SAC_RD_ACT;
          end
        end
        // read access running
        sac_pkg::SAC_RD_ACT: begin
          if (tmr_exp) begin
            state_q <= sac_pkg::SAC_RD_TURN;
          end
        end
        // device releasing the data pins
        sac_pkg::SAC_RD_TURN: begin
          if (tmr_exp) begin
            state_q <= sac_pkg::SAC_IDLE;
          end
        end
        // address and data settle with strobe high
        sac_pkg::SAC_WR_SETUP: begin
          state_q <= sac_pkg::SAC_WR_PULSE;
        end
        // write strobe low
        sac_pkg::SAC_WR_PULSE: begin
          if (tmr_exp) begin
            state_q <= sac_pkg::SAC_WR_END;
          end
        end
        // strobe risen, data still held
        sac_pkg::SAC_WR_END: begin
          state_q <= sac_pkg::SAC_IDLE;
        end
        // stray code recovers to idle
        default: begin
          state_q <= sac_pkg::SAC_IDLE;
        end
      endcase
    end
  end

  // select, enable and lane pins with the address
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addr_q <= 17'h00000;
      cs_n_q <= `SAC_STROBE_IDLE;
      oe_n_q <= `SAC_STROBE_IDLE;
      lanes_n_q <= `SAC_LANES_IDLE;
    end else if (clk_en) begin
      if (accept) begin
        // address set together with select falling edge
        addr_q <= req_addr;
        cs_n_q <= 1'b0;
        // writes keep output enable high so the device stays off the pins
        oe_n_q <= req_write;
        lanes_n_q <= ~lanes;
      end else if ((state_q == sac_pkg::SAC_RD_ACT) && tmr_exp) begin
        // end read: deselect puts the device in standby
        cs_n_q <= 1'b1;
        oe_n_q <= 1'b1;
        lanes_n_q <= `SAC_LANES_IDLE;
      end else if (state_q == sac_pkg::SAC_WR_END) begin
        // deselect one cycle after the strobe has ended the write
        cs_n_q <= 1'b1;
        lanes_n_q <= `SAC_LANES_IDLE;
      end
    end
  end

  // write strobe pin
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      we_n_q <= `SAC_STROBE_IDLE;
    end else if (clk_en) begin
      if (accept) begin
        // reads and write setup both start with the strobe high
        we_n_q <= 1'b1;
      end else if (state_q == sac_pkg::SAC_WR_SETUP) begin
        // overlap of all low strobes opens the write
        we_n_q <= 1'b0;
      end else if ((state_q == sac_pkg::SAC_WR_PULSE) && tmr_exp) begin
        // rising strobe is the edge that ends this write
        we_n_q <= 1'b1;
      end
    end
  end

  // data pin drive
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dq_o_q <= 16'h0000;
      dq_oe_q <= 16'h0000;
    end else if (clk_en) begin
      if (accept && req_write) begin
        // drive only selected lanes, a full cycle before the strobe falls
        dq_o_q <= req_wdata & sac_pkg::sac_lane_mask(lanes);
        dq_oe_q <= sac_pkg::sac_lane_mask(lanes);
      end else if (state_q == sac_pkg::SAC_WR_END) begin
        // held through the ending edge, dropped one cycle later
        dq_oe_q <= 16'h0000;
      end
    end
  end

  // user side handshake and answers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdy_q <= 1'b1;
      rd_valid_q <= 1'b0;
      wr_done_q <= 1'b0;
      rd_data_q <= 16'h0000;
    end else if (clk_en) begin
      rd_valid_q <= 1'b0;
      wr_done_q <= 1'b0;
      if (accept) begin
        rdy_q <= 1'b0;
      end else if ((state_q == sac_pkg::SAC_RD_ACT) && tmr_exp) begin
        // sample enabled lanes, zero the others
        rd_valid_q <= 1'b1;
        rd_data_q <= dq_i & sac_pkg::sac_lane_mask(~lanes_n_q);
      end else if ((state_q == sac_pkg::SAC_RD_TURN) && tmr_exp) begin
        rdy_q <= 1'b1;
      end else if (state_q == sac_pkg::SAC_WR_END) begin
        wr_done_q <= 1'b1;
        rdy_q <= 1'b1;
      end
    end
  end

  // outputs straight from flip-flops
  assign req_ready = rdy_q;
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign wr_done = wr_done_q;
  assign sram_addr = addr_q;
  assign chip_select_n = cs_n_q;
  assign output_enable_n = oe_n_q;
  assign write_strobe_n = we_n_q;
  assign lower_byte_lane_n = lanes_n_q[0];
  assign upper_byte_lane_n = lanes_n_q[1];
  assign dq_o = dq_o_q;
  assign dq_oe = dq_oe_q;

endmodule : sac_host

// >>> sim/sac_host_checker.sv
`timescale 1ns/1ps
`include "sac_consts.svh"

// watches the memory pins of the host controller
module sac_host_checker (
  // clock, reset, freeze
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  // user side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic rd_valid,
  input wire logic wr_done,
  input wire logic [`SAC_ADDR_W-1:0] req_addr,
  input wire logic [`SAC_DATA_W-1:0] req_wdata,
  input wire logic [`SAC_DATA_W-1:0] rd_data,
  input wire logic [1:0] req_be,
  // memory pins
  input wire logic [`SAC_ADDR_W-1:0] sram_addr,
  input wire logic [`SAC_DATA_W-1:0] dq_i,
  input wire logic [`SAC_DATA_W-1:0] dq_o,
  input wire logic [`SAC_DATA_W-1:0] dq_oe,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic lower_byte_lane_n,
  input wire logic upper_byte_lane_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // select still low at the strobe edge, released a few cycles later
  sequence s_close;
    !chip_select_n ##[1:8] chip_select_n;
  endsequence
  // read outputs released, select kept high for the turnaround cycle
  sequence s_turn;
    chip_select_n ##1 chip_select_n;
  endsequence
  property p_start;
    $fell(write_strobe_n) |-> !chip_select_n && !(lower_byte_lane_n && upper_byte_lane_n);
  endproperty
  a_start: assert property (p_start) else $error("write began without select and lane");
  property p_end;
    $rose(write_strobe_n) |-> s_close;
  endproperty
  a_end: assert property (p_end) else $error("write not ended by the strobe edge");
  property p_hold;
    $rose(write_strobe_n) |-> $stable(dq_o) && $stable(dq_oe) && dq_oe != 16'h0;
  endproperty
  a_hold: assert property (p_hold) else $error("write data moved at the ending edge");
  property p_addr;
    !chip_select_n && !$past(chip_select_n) |-> $stable(sram_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("address moved while selected");
  property p_setup;
    $fell(write_strobe_n) |-> $past(dq_oe) != 16'h0 && output_enable_n;
  endproperty
  a_setup: assert property (p_setup) else $error("write data not set up before strobe");
  property p_fight;
    (!output_enable_n || !$past(output_enable_n)) |-> dq_oe == 16'h0;
  endproperty
  a_fight: assert property (p_fight) else $error("host drove data during a read");
  property p_turn;
    $rose(output_enable_n) |-> s_turn;
  endproperty
  a_turn: assert property (p_turn) else $error("no turnaround after a read");
  property p_rd_we;
    !output_enable_n |-> write_strobe_n;
  endproperty
  a_rd_we: assert property (p_rd_we) else $error("write strobe low during a read");
endmodule : sac_host_checker

bind sac_host sac_host_checker u_chk (
  .clk_sys(clk_sys),
  .arst_n(arst_n),
  .clk_en(clk_en),
  .req_valid(req_valid),
  .req_write(req_write),
  .req_ready(req_ready),
  .rd_valid(rd_valid),
  .wr_done(wr_done),
  .req_addr(req_addr),
  .req_wdata(req_wdata),
  .rd_data(rd_data),
  .req_be(req_be),
  .sram_addr(sram_addr),
  .dq_i(dq_i),
  .dq_o(dq_o),
  .dq_oe(dq_oe),
  .chip_select_n(chip_select_n),
  .output_enable_n(output_enable_n),
  .write_strobe_n(write_strobe_n),
  .lower_byte_lane_n(lower_byte_lane_n),
  .upper_byte_lane_n(upper_byte_lane_n)
);

// >>> sim/sac_sram_model.sv
`timescale 1ns/1ps
`include "sac_consts.svh"

// behavioural 16-bit asynchronous static ram seen from its pins
module sac_sram_model #(
  parameter int T_ACC = 3
) (
  // address and strobes
  input wire logic [`SAC_ADDR_W-1:0] a,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic lo_n,
  input wire logic up_n,
  // host side of the data pins
  input wire logic [`SAC_DATA_W-1:0] ho,
  input wire logic [`SAC_DATA_W-1:0] he,
  // resolved data pins
  output logic [`SAC_DATA_W-1:0] dq
);
  logic [15:0] mem [0:131071]; // storage array
  logic [15:0] dev_en, drv, val, last, wd; // drive state and captured data
  logic [16:0] wa; // captured write address
  logic [1:0] wl; // captured lanes
  logic wr_act; // write interval open
  assign wr_act = !we_n && !cs_n && !(lo_n && up_n);
  // read data only on selected lanes, high impedance in standby or disabled
  assign #T_ACC dev_en = (!cs_n && !oe_n && we_n) ? {{8{!up_n}}, {8{!lo_n}}} : 16'h0;
  assign drv = dev_en | he;
  assign val = (dev_en & mem[a]) | (he & ho);
  // a released bit floats to the inverse of its last driven level
  always @(val, drv) last = (val & drv) | (last & ~drv);
  assign dq = (val & drv) | (~last & ~drv);
  // capture address, data and lanes while the interval is open
  always @* if (wr_act) begin
    wa = a;
    wd = dq;
    wl = {!up_n, !lo_n};
  end
  // first rising strobe closes the interval; only low lanes are stored
  always @(negedge wr_act) begin
    if (wl[0]) mem[wa][7:0] = wd[7:0];
    if (wl[1]) mem[wa][15:8] = wd[15:8];
  end
endmodule : sac_sram_model

// >>> sim/tb.sv
`timescale 1ns/1ps
`include "sac_consts.svh"

module tb;
  // controller ports, named as on the design
  logic clk_sys, arst_n, clk_en, req_valid, req_write, req_ready, rd_valid, wr_done;
  logic chip_select_n, output_enable_n, write_strobe_n, lower_byte_lane_n, upper_byte_lane_n;
  logic [`SAC_ADDR_W-1:0] req_addr, sram_addr;
  logic [`SAC_DATA_W-1:0] req_wdata, rd_data, dq_i, dq_o, dq_oe, q;
  logic [1:0] req_be;
  int fails, num_checks;
  // addresses used: both ends and a middle one
  logic [16:0] adr [3] = '{17'h0, 17'h1ffff, 17'h0a5a5};
  sac_host uut (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .req_valid(req_valid),
    .req_write(req_write),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .req_be(req_be),
    .req_ready(req_ready),
    .rd_valid(rd_valid),
    .rd_data(rd_data),
    .wr_done(wr_done),
    .sram_addr(sram_addr),
    .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n),
    .write_strobe_n(write_strobe_n),
    .lower_byte_lane_n(lower_byte_lane_n),
    .upper_byte_lane_n(upper_byte_lane_n),
    .dq_i(dq_i),
    .dq_o(dq_o),
    .dq_oe(dq_oe)
  );
  // far side memory, also resolves the shared data pins
  sac_sram_model mem (.a(sram_addr), .cs_n(chip_select_n), .oe_n(output_enable_n),
    .we_n(write_strobe_n), .lo_n(lower_byte_lane_n), .up_n(upper_byte_lane_n),
    .ho(dq_o), .he(dq_oe), .dq(dq_i));
  // system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // counts and verdict
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // compare one word
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // one request, optionally freezing the clock enable after it is taken
  task op(input logic wr, input logic [16:0] a, input logic [15:0] d,
          input logic [1:0] be, input int frz);
    int n;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > 20) begin
        fails++;
        report_and_stop();
      end
    end
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_be = be;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    if (frz > 0) begin
      clk_en = 1'b0;
      repeat (frz) @(posedge clk_sys);
      #1;
      clk_en = 1'b1;
    end
    n = 0;
    while ((wr ? wr_done : rd_valid) !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > 20) begin
        fails++;
        report_and_stop();
      end
    end
    q = rd_data;
  endtask : op
  // whole words at both address ends and the middle one, written then read back to back
  task t_word;
    for (int i = 0; i < 3; i++) op(1'b1, adr[i], 16'ha5c3 ^ 16'(i), 2'h0, 0);
    for (int i = 0; i < 3; i++) begin
      op(1'b0, adr[i], 16'h0, 2'h3, 0);
      chk(q, 16'ha5c3 ^ 16'(i));
    end
  endtask : t_word
  // single lane writes merge, single lane reads return that lane only
  task t_lanes;
    logic [15:0] m, e;
    e = 16'ha5c3;
    for (int b = 1; b < 3; b++) begin
      m = {{8{b[1]}}, {8{b[0]}}};
      op(1'b1, adr[0], 16'h3c96 ^ {16{b[0]}}, b[1:0], 0);
      e = (e & ~m) | ((16'h3c96 ^ {16{b[0]}}) & m);
      op(1'b0, adr[0], 16'h0, 2'h3, 0);
      chk(q, e);
      op(1'b0, adr[0], 16'h0, b[1:0], 0);
      chk(q, e & m);
    end
  endtask : t_lanes
  // clock enable held low in mid write and mid read
  task t_freeze;
    op(1'b1, adr[1], 16'h7e81, 2'h0, 3);
    op(1'b0, adr[1], 16'h0, 2'h0, 3);
    chk(q, 16'h7e81);
  endtask : t_freeze
  // reset cut into a write pulse, then a clean write and read back
  task t_reset;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b1;
    req_write = 1'b1;
    req_addr = adr[2];
    req_wdata = 16'h1234;
    req_be = 2'h0;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    @(posedge clk_sys);
    #1;
    chk({15'h0, write_strobe_n}, 16'h0000);
    arst_n = 1'b0;
    #1;
    chk({12'h0, chip_select_n, output_enable_n, write_strobe_n, req_ready}, 16'h000f);
    chk(dq_oe, 16'h0000);
    repeat (2) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    op(1'b1, adr[2], 16'h5aa5, 2'h0, 0);
    op(1'b0, adr[2], 16'h0, 2'h0, 0);
    chk(q, 16'h5aa5);
  endtask : t_reset
  // reset, then the scenarios
  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 17'h0;
    req_wdata = 16'h0;
    req_be = 2'h0;
    fails = 0;
    num_checks = 0;
    repeat (6) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    chk(dq_oe, 16'h0);
    t_word();
    t_lanes();
    t_freeze();
    t_reset();
    report_and_stop();
  end
endmodule : tb
